// File: hdl/mao_defs.svh
// Constants for the move/OR instruction executor
`ifndef MAO_DEFS_SVH
`define MAO_DEFS_SVH
`define MAO_INSTR_W 14
`define MAO_DATA_W 8
`define MAO_ADDR_W 7
`define MAO_FILE_DEPTH 128
`define MAO_DIR_BIT 7
`define MAO_OP_OR_FILE 6'h04
`define MAO_OP_MOVE_FILE 6'h08
`define MAO_OP_STORE 6'h00
`define MAO_LIT_TOP 2'h3
`define MAO_LIT_SUB 2'h0
`define MAO_W_RESET 8'h00
`define MAO_Z_RESET 1'b0
`endif

// File: hdl/mao_pkg.sv
// Types shared by the move/OR instruction executor
package mao_pkg;
    typedef enum logic [2:0] {
        MAO_OP_NONE = 3'b000,
        MAO_OP_OR = 3'b001,
        MAO_OP_MOVE = 3'b010,
        MAO_OP_LIT = 3'b011,
        MAO_OP_STO = 3'b100
    } mao_op_type;
    typedef struct packed {
        mao_op_type op;
        logic dir;
        logic [6:0] addr;
        logic [7:0] lit;
    } mao_dec_type;
endpackage

// File: hdl/mao_decode.sv
// Instruction word decoder for the four supported instructions
`timescale 1ns/100ps
`default_nettype none
`include "mao_defs.svh"
module mao_decode
    import mao_pkg::*;
(
    // Instruction word
    input wire logic [13:0] instr,
    // Decoded fields
    output var mao_dec_type dec
);
    // Opcode pattern matches; literal ignores bits 9:8 entirely
    wire logic is_or = (instr[13:8] == `MAO_OP_OR_FILE); // [RL1]
    wire logic is_move = (instr[13:8] == `MAO_OP_MOVE_FILE); // [RL3]
    wire logic is_lit = (instr[13:12] == `MAO_LIT_TOP) &&
                        (instr[11:10] == `MAO_LIT_SUB); // [RL6] [RL7]
    wire logic is_sto = (instr[13:8] == `MAO_OP_STORE) && instr[`MAO_DIR_BIT]; // [RL8]
    wire mao_op_type op_sel = is_or ? MAO_OP_OR :
                              is_move ? MAO_OP_MOVE :
                              is_lit ? MAO_OP_LIT :
                              is_sto ? MAO_OP_STO : MAO_OP_NONE;
    // Pack fields for the executor
    assign dec = '{op: op_sel, dir: instr[`MAO_DIR_BIT], addr: instr[6:0], lit: instr[7:0]};
endmodule // mao_decode
`default_nettype wire

// File: hdl/mao_exec.sv
// Single-cycle executor for OR, move, literal load and store
`timescale 1ns/100ps
`default_nettype none
`include "mao_defs.svh"
// Notes on behaviour
// RL1: The OR opcode ORs the working register with file register 0..127 and updates zero.
// RL2: For OR, direction 0 writes the working register and direction 1 writes the file register.
// RL3: The move opcode passes the addressed file register value unchanged to the destination.
// RL4: For move, direction 0 targets the working register and direction 1 the same file register.
// RL5: Move updates the zero flag for either destination, so a self move tests for zero.
// RL6: The literal opcode loads the low eight bits into the working register, flags untouched.
// RL7: The two don't-care bits of the literal opcode are ignored by the decoder.
// RL8: The store opcode copies the working register into the file register, flags untouched.
// RL9: Every instruction here takes one word and completes in one cycle with no skip.
// RL10: Zero is set when the written eight-bit result is zero and cleared otherwise.
module mao_exec
    import mao_pkg::*;
#(
    parameter int DATA_W = `MAO_DATA_W,
    parameter int DEPTH = `MAO_FILE_DEPTH
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Instruction issue
    input wire logic INSTR_VALID,
    input wire logic [13:0] INSTR,
    // Architectural state
    output logic [7:0] W_OUT,
    output logic Z_OUT,
    // Write observation and completion
    output logic FILE_WE,
    output logic [6:0] FILE_ADDR,
    output logic [7:0] FILE_WDATA,
    output logic DONE
);
    // Decoded word, data file and architectural state
    mao_dec_type dec;
    logic [DATA_W-1:0] file_mem [DEPTH];
    logic [7:0] w_reg;
    logic z_reg;
    logic we_reg;
    logic [6:0] addr_reg;
    logic [7:0] wdata_reg;
    logic done_reg;

    // Decoder instance
    mao_decode mao_decode_inst (
        .instr(INSTR),
        .dec(dec)
    );

    // Operand fetch and result selection
    wire logic [7:0] f_val = file_mem[dec.addr];
    wire logic is_or = INSTR_VALID && (dec.op == MAO_OP_OR);
    wire logic is_mv = INSTR_VALID && (dec.op == MAO_OP_MOVE);
    wire logic is_lt = INSTR_VALID && (dec.op == MAO_OP_LIT);
    wire logic is_st = INSTR_VALID && (dec.op == MAO_OP_STO);
    wire logic [7:0] result = is_or ? (w_reg | f_val) : // [RL1]
                              is_mv ? f_val : // [RL3]
                              is_lt ? dec.lit : w_reg; // [RL6] [RL8]
    // Destination and flag update selection
    wire logic to_file = ((is_or || is_mv) && dec.dir) || is_st; // [RL2] [RL4] [RL8]
    wire logic to_w = ((is_or || is_mv) && !dec.dir) || is_lt; // [RL2] [RL4] [RL6]
    wire logic z_upd = is_or || is_mv; // [RL5]
    wire logic [7:0] w_next = to_w ? result : w_reg;
    wire logic z_next = z_upd ? (result == 8'h00) : z_reg; // [RL10]

    // Architectural state, one cycle per instruction
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            w_reg <= `MAO_W_RESET;
            z_reg <= `MAO_Z_RESET;
            we_reg <= 1'b0;
            addr_reg <= 7'h00;
            wdata_reg <= 8'h00;
            done_reg <= 1'b0;
        end else begin
            w_reg <= w_next; // [RL9]
            z_reg <= z_next;
            we_reg <= to_file;
            addr_reg <= dec.addr;
            wdata_reg <= result;
            done_reg <= INSTR_VALID;
        end
    end

    // File array, no reset so it maps to memory
    always_ff @(posedge CLK) begin
        if (to_file) begin
            file_mem[dec.addr] <= result;
        end
    end

    // Outputs come straight from the state flops
    assign W_OUT = w_reg;
    assign Z_OUT = z_reg;
    assign FILE_WE = we_reg;
    assign FILE_ADDR = addr_reg;
    assign FILE_WDATA = wdata_reg;
    assign DONE = done_reg;

    // Checks
    // Issue of each kind is matched on the raw word, not on the decoder,
    // so that a decoding slip fails here instead of agreeing with itself
    sequence s_or_issue;
        INSTR_VALID && INSTR[13:8] == 6'h04;
    endsequence
    sequence s_or_to_w;
        s_or_issue and !INSTR[7];
    endsequence
    sequence s_or_to_f;
        s_or_issue and INSTR[7];
    endsequence
    sequence s_move_issue;
        INSTR_VALID && INSTR[13:8] == 6'h08;
    endsequence
    sequence s_move_to_w;
        s_move_issue and !INSTR[7];
    endsequence
    sequence s_move_to_f;
        s_move_issue and INSTR[7];
    endsequence
    // Bits 9:8 left out on purpose, they are don't-care
    sequence s_lit_issue;
        INSTR_VALID && INSTR[13:10] == 4'hC;
    endsequence
    sequence s_store_issue;
        INSTR_VALID && INSTR[13:7] == 7'h01;
    endsequence
    // Cycle in which nothing is taken
    sequence s_idle;
        !INSTR_VALID;
    endsequence
    // Valid word that none of the four patterns claims
    sequence s_other_issue;
        INSTR_VALID && INSTR[13:8] != 6'h04 && INSTR[13:8] != 6'h08 &&
            INSTR[13:10] != 4'hC && INSTR[13:7] != 7'h01;
    endsequence

    // OR with file
    AST_OR_ZERO: assert property (@(posedge CLK) disable iff (!RESETN) // [RL1]
        s_or_issue |=> Z_OUT == (($past(w_reg) | $past(f_val)) == 8'h00))
        else $error("OR zero flag wrong");
    AST_OR_DEST_W: assert property (@(posedge CLK) disable iff (!RESETN) // [RL2]
        s_or_to_w |=> W_OUT == ($past(w_reg) | $past(f_val)) && !FILE_WE)
        else $error("OR to working wrong");
    AST_OR_DEST_F: assert property (@(posedge CLK) disable iff (!RESETN) // [RL2]
        s_or_to_f |=> FILE_WE && $stable(W_OUT))
        else $error("OR to file wrong");
    AST_OR_F_DATA: assert property (@(posedge CLK) disable iff (!RESETN) // [RL2]
        s_or_to_f |=> FILE_WDATA == ($past(w_reg) | $past(f_val)) &&
            FILE_ADDR == $past(INSTR[6:0]))
        else $error("OR file write data or address wrong");

    // File move
    AST_MOVE_W: assert property (@(posedge CLK) disable iff (!RESETN) // [RL3]
        s_move_to_w |=> W_OUT == $past(f_val))
        else $error("Move to working wrong");
    AST_MOVE_F: assert property (@(posedge CLK) disable iff (!RESETN) // [RL4]
        s_move_to_f |=> FILE_WE && FILE_WDATA == $past(f_val))
        else $error("Move to file wrong");
    AST_MOVE_Z: assert property (@(posedge CLK) disable iff (!RESETN) // [RL5]
        s_move_issue |=> Z_OUT == (FILE_WDATA == 8'h00))
        else $error("Move zero flag wrong");
    AST_MOVE_W_NO_WR: assert property (@(posedge CLK) disable iff (!RESETN) // [RL4]
        s_move_to_w |=> !FILE_WE)
        else $error("Move to working wrote the file");
    AST_MOVE_F_ADDR: assert property (@(posedge CLK) disable iff (!RESETN) // [RL4]
        s_move_to_f |=> FILE_ADDR == $past(INSTR[6:0]) && $stable(W_OUT))
        else $error("Move to file address or working wrong");

    // Literal load
    AST_LIT: assert property (@(posedge CLK) disable iff (!RESETN) // [RL6]
        s_lit_issue |=> W_OUT == $past(INSTR[7:0]) && $stable(Z_OUT))
        else $error("Literal load wrong");
    AST_LIT_DC: assert property (@(posedge CLK) disable iff (!RESETN) // [RL7]
        s_lit_issue |-> is_lt)
        else $error("Literal not decoded");
    AST_LIT_NO_WR: assert property (@(posedge CLK) disable iff (!RESETN) // [RL6]
        s_lit_issue |=> !FILE_WE)
        else $error("Literal load wrote the file");

    // Store
    AST_STORE: assert property (@(posedge CLK) disable iff (!RESETN) // [RL8]
        s_store_issue |=> FILE_WE && FILE_WDATA == $past(w_reg) && $stable(Z_OUT))
        else $error("Store wrong");
    AST_STORE_ADDR: assert property (@(posedge CLK) disable iff (!RESETN) // [RL8]
        s_store_issue |=> FILE_ADDR == $past(INSTR[6:0]) && $stable(W_OUT))
        else $error("Store address or working wrong");

    // Zero flag and the only paths that may change state
    AST_Z_RULE: assert property (@(posedge CLK) disable iff (!RESETN) // [RL10]
        z_upd && to_file |=> Z_OUT == (FILE_WDATA == 8'h00))
        else $error("Zero flag mismatch");
    AST_Z_RULE_W: assert property (@(posedge CLK) disable iff (!RESETN) // [RL10]
        z_upd && to_w |=> Z_OUT == (W_OUT == 8'h00))
        else $error("Zero flag mismatch on working result");
    AST_Z_WRITERS: assert property (@(posedge CLK) disable iff (!RESETN) // [RL6]
        !$stable(Z_OUT) |-> $past(z_upd))
        else $error("Zero flag changed without an updating instruction");
    AST_W_WRITERS: assert property (@(posedge CLK) disable iff (!RESETN) // [RL2]
        !$stable(W_OUT) |-> $past(to_w))
        else $error("Working register changed without a writer");

    // One-cycle completion, quiet idle cycles, unclaimed words
    AST_ONE_CYCLE: assert property (@(posedge CLK) disable iff (!RESETN) // [RL9]
        INSTR_VALID |=> DONE)
        else $error("Instruction not done in one cycle");
    AST_DONE_ONLY: assert property (@(posedge CLK) disable iff (!RESETN) // [RL9]
        DONE |-> $past(INSTR_VALID))
        else $error("Done without an instruction");
    AST_IDLE_QUIET: assert property (@(posedge CLK) disable iff (!RESETN) // [RL9]
        s_idle |=> !DONE && !FILE_WE && $stable(W_OUT) && $stable(Z_OUT))
        else $error("Idle cycle changed state");
    AST_OTHER_NOP: assert property (@(posedge CLK) disable iff (!RESETN) // [RL9]
        s_other_issue |=> DONE && !FILE_WE && $stable(W_OUT) && $stable(Z_OUT))
        else $error("Unclaimed word changed state");

    // Write-back is in the array by the next cycle
    AST_FILE_RAW: assert property (@(posedge CLK) disable iff (!RESETN) // [RL9]
        FILE_WE |-> file_mem[FILE_ADDR] == FILE_WDATA)
        else $error("File write not visible next cycle");
endmodule // mao_exec
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the move/OR instruction executor
`timescale 1ns/100ps
`default_nettype none
module tb;
    import mao_pkg::*;
    typedef struct packed {
        logic [7:0] w;
        logic z;
        logic we;
        logic [6:0] a;
        logic [7:0] d;
    } mao_note_type;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic INSTR_VALID = 1'b0;
    logic [13:0] INSTR = 14'h0000;
    logic [7:0] W_OUT, FILE_WDATA;
    logic [6:0] FILE_ADDR;
    logic Z_OUT, FILE_WE, DONE;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h0000_509F;
    logic [31:0] r;
    logic [7:0] mem [128];
    logic [7:0] w = 8'h00;
    logic z = 1'b0;
    mao_note_type q [$];
    mao_note_type got;
    mao_exec mao_exec_inst (.CLK(CLK), .RESETN(RESETN), .INSTR_VALID(INSTR_VALID),
        .INSTR(INSTR), .W_OUT(W_OUT), .Z_OUT(Z_OUT), .FILE_WE(FILE_WE),
        .FILE_ADDR(FILE_ADDR), .FILE_WDATA(FILE_WDATA), .DONE(DONE));
    // Clock, 8 ns period
    initial forever #4 CLK = ~CLK;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] act);
        tests_run++;
        if (exp !== act) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, act);
        end
    endtask
    // Model the instruction, note the result, then present it for one edge
    task automatic issue(input logic [13:0] ins);
        mao_note_type n;
        logic [7:0] v;
        n = '0;
        v = mem[ins[6:0]];
        if (ins[13:8] == 6'h04 || ins[13:8] == 6'h08) begin
            v = (ins[13:8] == 6'h04) ? (w | v) : v;
            z = (v == 8'h00);
            if (ins[7]) begin
                mem[ins[6:0]] = v;
                n.we = 1'b1;
                n.d = v;
            end else
                w = v;
        end else if (ins[13:10] == 4'hC)
            w = ins[7:0];
        else if (ins[13:7] == 7'h01) begin
            mem[ins[6:0]] = w;
            n.we = 1'b1;
            n.d = w;
        end
        n.a = ins[6:0];
        n.w = w;
        n.z = z;
        q.push_back(n);
        @(posedge CLK);
        INSTR_VALID <= 1'b1;
        INSTR <= ins;
    endtask
    // Gap cycle with noise on the word, which must be ignored
    task automatic idle();
        @(posedge CLK);
        INSTR_VALID <= 1'b0;
        INSTR <= seed[13:0];
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Each completion takes the oldest note; outputs are settled at the falling edge
    always @(negedge CLK) begin
        if (RESETN === 1'b1 && DONE === 1'b1) begin
            got = (q.size() > 0) ? q.pop_front() : 'x;
            check("W_OUT", got.w, W_OUT);
            check("Z_OUT", {7'h00, got.z}, {7'h00, Z_OUT});
            check("FILE_WE", {7'h00, got.we}, {7'h00, FILE_WE});
            if (got.we === 1'b1) begin
                check("FILE_ADDR", {1'b0, got.a}, {1'b0, FILE_ADDR});
                check("FILE_WDATA", got.d, FILE_WDATA);
            end
        end
    end
    // Watchdog, several times the expected run length
    initial begin
        repeat (3000) @(posedge CLK);
        n_mismatch++;
        end_of_test();
    end
    // Main sequence: fill every address, zero cases, then a random mix
    initial begin
        repeat (20) @(posedge CLK);
        check("W_OUT", 8'h00, W_OUT);
        check("Z_OUT", 8'h00, {7'h00, Z_OUT});
        RESETN <= 1'b1;
        for (int i = 0; i < 128; i++) begin
            r = rnd();
            issue({4'hC, r[9:0]});
            issue({7'h01, i[6:0]});
        end
        issue(14'h3200);
        issue(14'h0089);
        issue(14'h0889);
        issue(14'h0409);
        issue(14'h30FF);
        issue(14'h008A);
        // Mid-run reset: state clears, the data file keeps its contents
        idle();
        repeat (2) @(posedge CLK);
        RESETN <= 1'b0;
        @(posedge CLK);
        check("W_OUT", 8'h00, W_OUT);
        check("Z_OUT", 8'h00, {7'h00, Z_OUT});
        check("FILE_WE", 8'h00, {7'h00, FILE_WE});
        check("DONE", 8'h00, {7'h00, DONE});
        w = 8'h00;
        z = 1'b0;
        RESETN <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            r = rnd();
            case (r[18:16])
                3'd0: issue({6'h04, r[7:0]});
                3'd1: issue({6'h08, r[7:0]});
                3'd2: issue({4'hC, r[9:0]});
                3'd3: issue({7'h01, r[6:0]});
                3'd4: issue({6'h0E, r[7:0]});
                3'd5: idle();
                default: issue({r[19] ? 6'h04 : 6'h08, 1'b0, r[6:0] & 7'h07});
            endcase
        end
        idle();
        repeat (3) @(posedge CLK);
        check("queue", 8'h00, 8'(q.size()));
        end_of_test();
    end
endmodule // tb
`default_nettype wire
